// >>> rtl/hpc_consts.vh
// Purpose: constants for the host port and control pin block
// Assumes: plain Verilog-2005, included by bare name
// Notes: reset values of the pin-facing registers and mode encodings
// Behaviour
// - serial port is an I2C target when mode select is 1, SPI when 0.
// - data pin two-way in I2C and 3-wire SPI, input only in 4-wire SPI.
// - second pin is upper address select in I2C, serial data out in 4-wire SPI.
// - third pin is lower address select in I2C, active-low chip select in SPI.
// - host supplies serial clock on one pin, used in both modes.
// - interrupt output driven low, push-pull, whenever a status change occurred; a change is not latched while device reset is held.
// - low device reset performs full power-on reset of logic and registers.
// - clock outputs stay disabled while device reset is held.
// - outputs disabled while output enable pin is high, run while low.
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH
`define HPC_MODE_I2C      1'h1
`define HPC_MODE_SPI      1'h0
`define HPC_MODE_RST      1'h1
`define HPC_OE_N_RST      1'h0
`define HPC_IRQ_N_RST     1'h1
`define HPC_CLK_EN_RST    1'h0
`define HPC_SYNC_RST      2'h0
`define HPC_RST_N_RST     1'h0
`define HPC_SCLK_RST      1'h1
`define HPC_SDA_RST       1'h1
`define HPC_UPPER_RST     1'h0
`define HPC_CSN_RST       1'h1
`define HPC_LOWER_RST     1'h1
`define HPC_PULSE_RST     1'h0
`define HPC_DRIVE_RST     1'h0
`define HPC_PENDING_RST   1'h0
`define HPC_DEV_RST_RST   1'h1
`endif

// >>> rtl/hpc_sync2.v
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk_in
// Notes: first stage read only by the second stage
module hpc_sync2 #(
    parameter RST_VAL = 1'h0
) (
    // clock and reset
    input  wire clk_in,
    input  wire rst_in,
    // level
    input  wire d_in,
    output reg  q_out
);
    reg meta;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta  <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

// >>> rtl/hpc_host_pins.v
// Purpose: host port pin mux and control pins of a clock generator
// Assumes: sys_clk_in at 250 MHz; all pins asynchronous, two-flop synchronised
// Notes: serial protocol engines sit outside; this block routes pins to them
`include "hpc_consts.vh"
module hpc_host_pins (
    // clock and reset
    input  wire sys_clk_in,
    input  wire rst_in,
    // mode strap and control pins
    input  wire mode_select_in,
    input  wire device_reset_n_in,
    input  wire output_enable_n_in,
    // shared serial pins
    input  wire sclk_in,
    input  wire sda_in,
    input  wire sdo_upper_in,
    input  wire chip_select_n_in,
    output reg  sda_out,
    output reg  sda_oe_out,
    output reg  sdo_upper_out,
    output reg  sdo_upper_oe_out,
    // protocol engine side
    input  wire spi_four_wire_in,
    input  wire engine_sda_drive_low_in,
    input  wire engine_spi_data_in,
    input  wire engine_spi_data_oe_in,
    output reg  i2c_mode_out,
    output reg  serial_clk_out,
    output reg  serial_clk_rise_out,
    output reg  serial_data_out,
    output reg  target_address_upper_select_out,
    output reg  target_address_lower_select_out,
    output reg  chip_select_n_out,
    // status and outputs
    input  wire status_change_in,
    input  wire status_clear_in,
    output reg  status_change_irq_n_out,
    output reg  device_reset_out,
    output reg  clock_outputs_enable_out
);
    // synchronised pin levels
    wire mode_s;
    wire rst_n_s;
    wire oe_n_s;
    wire sclk_s;
    wire sda_s;
    wire upper_s;
    wire csn_s;
    // decoded roles
    wire soft_rst;
    wire i2c;
    wire spi4;
    wire spi3;
    // serial clock edge and status flag
    reg  sclk_d;
    reg  pending;
    reg  next_pending;

    hpc_sync2 #(
        .RST_VAL (`HPC_MODE_RST)
    ) u_mode (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (mode_select_in),
        .q_out  (mode_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_RST_N_RST)
    ) u_rst (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (device_reset_n_in),
        .q_out  (rst_n_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_OE_N_RST)
    ) u_oe (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (output_enable_n_in),
        .q_out  (oe_n_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_SCLK_RST)
    ) u_sclk (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (sclk_in),
        .q_out  (sclk_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_SDA_RST)
    ) u_sda (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (sda_in),
        .q_out  (sda_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_UPPER_RST)
    ) u_upper (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (sdo_upper_in),
        .q_out  (upper_s)
    );

    hpc_sync2 #(
        .RST_VAL (`HPC_CSN_RST)
    ) u_csn (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (chip_select_n_in),
        .q_out  (csn_s)
    );

    assign soft_rst = ~rst_n_s;
    // mode decode
    // every pin role below reads the same synchronised mode, so roles switch on one edge
    assign i2c      = (mode_s == `HPC_MODE_I2C);
    assign spi4     = ~i2c & spi_four_wire_in;
    assign spi3     = ~i2c & ~spi_four_wire_in;

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            i2c_mode_out <= `HPC_MODE_RST;
        end else begin
            i2c_mode_out <= mode_s;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_d              <= `HPC_SCLK_RST;
            serial_clk_out      <= `HPC_SCLK_RST;
            serial_clk_rise_out <= `HPC_PULSE_RST;
        end else begin
            sclk_d              <= sclk_s;
            serial_clk_out      <= sclk_s;
            serial_clk_rise_out <= sclk_s & ~sclk_d;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_data_out <= `HPC_SDA_RST;
            sda_out         <= `HPC_DRIVE_RST;
            sda_oe_out      <= `HPC_DRIVE_RST;
        end else begin
            serial_data_out <= sda_s;
            if (soft_rst) begin
                sda_out    <= `HPC_DRIVE_RST;
                sda_oe_out <= `HPC_DRIVE_RST;
            end else if (i2c) begin
                // only ever pulls low, the external pull-up gives the high level
                sda_out    <= 1'h0;
                sda_oe_out <= engine_sda_drive_low_in;
            end else if (spi3) begin
                sda_out    <= engine_spi_data_in;
                sda_oe_out <= engine_spi_data_oe_in;
            end else begin
                // 4-wire: the pin is an input only
                sda_out    <= 1'h0;
                sda_oe_out <= 1'h0;
            end
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            target_address_upper_select_out <= `HPC_UPPER_RST;
            sdo_upper_out                   <= `HPC_DRIVE_RST;
            sdo_upper_oe_out                <= `HPC_DRIVE_RST;
        end else begin
            target_address_upper_select_out <= i2c ? upper_s : 1'h0;
            sdo_upper_out                   <= spi4 ? engine_spi_data_in : 1'h0;
            // drive only while selected, so the line stays free for other targets
            sdo_upper_oe_out                <= spi4 & ~soft_rst & ~csn_s;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            target_address_lower_select_out <= `HPC_LOWER_RST;
            chip_select_n_out               <= `HPC_CSN_RST;
        end else begin
            target_address_lower_select_out <= i2c ? csn_s : 1'h0;
            chip_select_n_out               <= i2c ? 1'h1 : csn_s;
        end
    end

    always @* begin
        next_pending = pending;
        if (soft_rst) begin
            next_pending = 1'h0;
        end else if (status_change_in) begin
            next_pending = 1'h1;
        end else if (status_clear_in) begin
            next_pending = 1'h0;
        end
    end

    // status change irq
    // irq follows the next flag value, so set and clear both show on the same edge as the flag
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pending                 <= `HPC_PENDING_RST;
            status_change_irq_n_out <= `HPC_IRQ_N_RST;
        end else begin
            pending                 <= next_pending;
            status_change_irq_n_out <= ~next_pending;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            device_reset_out         <= `HPC_DEV_RST_RST;
            clock_outputs_enable_out <= `HPC_CLK_EN_RST;
        end else begin
            device_reset_out         <= soft_rst;
            clock_outputs_enable_out <= ~soft_rst & ~oe_n_s;
        end
    end
endmodule

// >>> testbench/hpc_host_pins_sva.sv
// Purpose: port assertions for the host pin block
// Assumes: pins settle within four edges
// Notes: bound to the block
module hpc_host_pins_sva (
    input wire logic sys_clk_in, rst_in, mode_select_in, device_reset_n_in, output_enable_n_in,
    input wire logic status_change_in, status_clear_in, i2c_mode_out, sda_out, sda_oe_out,
    input wire logic serial_clk_out, serial_clk_rise_out, chip_select_n_out, target_address_upper_select_out,
    input wire logic target_address_lower_select_out, status_change_irq_n_out, device_reset_out,
    input wire logic clock_outputs_enable_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_clear;
        status_clear_in && !status_change_in;
    endsequence
    a_mode_follow: assert property (mode_select_in [*4] |-> i2c_mode_out)
        else $error("mode wrong");
    a_i2c_sda_low: assert property (i2c_mode_out && sda_oe_out |-> !sda_out)
        else $error("sda high");
    a_spi_addr_zero: assert property (!i2c_mode_out |-> !target_address_upper_select_out)
        else $error("addr in spi");
    a_i2c_cs_high: assert property (i2c_mode_out |-> chip_select_n_out)
        else $error("cs in i2c");
    a_rise_pulse: assert property (serial_clk_rise_out |-> serial_clk_out ##1 !serial_clk_rise_out)
        else $error("rise pulse");
    a_irq_set: assert property (status_change_in ##1 !device_reset_out |-> !status_change_irq_n_out)
        else $error("irq not set");
    a_irq_clear: assert property (s_clear |=> status_change_irq_n_out)
        else $error("irq not clear");
    a_dev_rst_off: assert property (device_reset_out [*2] |-> !clock_outputs_enable_out)
        else $error("out in reset");
    a_oe_pin_off: assert property (output_enable_n_in [*4] |-> !clock_outputs_enable_out)
        else $error("out while oe high");
endmodule
bind hpc_host_pins hpc_host_pins_sva hpc_host_pins_sva_i (
    .sys_clk_in (sys_clk_in), .rst_in (rst_in), .mode_select_in (mode_select_in),
    .device_reset_n_in (device_reset_n_in), .output_enable_n_in (output_enable_n_in),
    .status_change_in (status_change_in), .status_clear_in (status_clear_in), .i2c_mode_out (i2c_mode_out),
    .sda_out (sda_out), .sda_oe_out (sda_oe_out), .serial_clk_out (serial_clk_out),
    .serial_clk_rise_out (serial_clk_rise_out), .chip_select_n_out (chip_select_n_out),
    .target_address_upper_select_out (target_address_upper_select_out),
    .target_address_lower_select_out (target_address_lower_select_out),
    .status_change_irq_n_out (status_change_irq_n_out), .device_reset_out (device_reset_out),
    .clock_outputs_enable_out (clock_outputs_enable_out)
);

// >>> testbench/hpc_host_model.sv
// Purpose: host side serial clock source
// Assumes: clock stands low between frames
// Notes: 160 ns period
module hpc_host_model (
    input  wire logic run_in,
    output logic      sclk_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial sclk_out = 1'b0;
    always begin
        wait (run_in);
        #80 sclk_out = 1'b1;
        #80 sclk_out = 1'b0;
    end
endmodule

// >>> testbench/hpc_host_pins_bench.sv
// Purpose: self-checking bench for the host pin block
// Assumes: inputs change 1 ns after the rising edge
// Notes: waits of 4 cycles cover the pin latency
module hpc_host_pins_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_in = 0, rst_in = 1, mode_select_in = 1, device_reset_n_in = 1, output_enable_n_in = 0;
    logic sda_in = 1, sdo_upper_in = 0, chip_select_n_in = 1, spi_four_wire_in = 0, engine_sda_drive_low_in = 0;
    logic engine_spi_data_in = 0, engine_spi_data_oe_in = 0, status_change_in = 0, status_clear_in = 0, run = 0;
    logic sclk_in, sda_out, sda_oe_out, sdo_upper_out, sdo_upper_oe_out, i2c_mode_out, serial_clk_out;
    logic serial_clk_rise_out, serial_data_out, target_address_upper_select_out, target_address_lower_select_out;
    logic chip_select_n_out, status_change_irq_n_out, device_reset_out, clock_outputs_enable_out;
    int error_cnt = 0, n_tests = 0, cycles = 0, rises;
    hpc_host_pins hpc_host_pins_i (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .mode_select_in (mode_select_in),
        .device_reset_n_in (device_reset_n_in), .output_enable_n_in (output_enable_n_in),
        .sclk_in (sclk_in), .sda_in (sda_in), .sdo_upper_in (sdo_upper_in), .chip_select_n_in (chip_select_n_in),
        .sda_out (sda_out), .sda_oe_out (sda_oe_out), .sdo_upper_out (sdo_upper_out),
        .sdo_upper_oe_out (sdo_upper_oe_out), .spi_four_wire_in (spi_four_wire_in),
        .engine_sda_drive_low_in (engine_sda_drive_low_in), .engine_spi_data_in (engine_spi_data_in),
        .engine_spi_data_oe_in (engine_spi_data_oe_in), .i2c_mode_out (i2c_mode_out),
        .serial_clk_out (serial_clk_out), .serial_clk_rise_out (serial_clk_rise_out),
        .serial_data_out (serial_data_out),
        .target_address_upper_select_out (target_address_upper_select_out),
        .target_address_lower_select_out (target_address_lower_select_out),
        .chip_select_n_out (chip_select_n_out), .status_change_in (status_change_in),
        .status_clear_in (status_clear_in), .status_change_irq_n_out (status_change_irq_n_out),
        .device_reset_out (device_reset_out), .clock_outputs_enable_out (clock_outputs_enable_out)
    );
    hpc_host_model hpc_host_model_i (.run_in(run), .sclk_out(sclk_in));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic t_i2c;
        sda_in = 0; sdo_upper_in = 1; chip_select_n_in = 0; engine_sda_drive_low_in = 1; cyc(4);
        chk("mode", 1, i2c_mode_out);
        chk("sdi", 0, serial_data_out);
        chk("sda_oe", 1, sda_oe_out);
        chk("upper", 1, target_address_upper_select_out);
        chk("lower", 0, target_address_lower_select_out);
        chk("cs", 1, chip_select_n_out);
        engine_sda_drive_low_in = 0;
        sda_in = 1;
    endtask
    task automatic t_spi;
        mode_select_in = 0; spi_four_wire_in = 1; engine_spi_data_in = 1; engine_spi_data_oe_in = 1; cyc(4);
        chk("cs", 0, chip_select_n_out);
        chk("sdo", 1, sdo_upper_oe_out && sdo_upper_out);
        chk("sda_oe", 0, sda_oe_out);
        spi_four_wire_in = 0; cyc(2);
        chk("sdio", 1, sda_oe_out && sda_out);
        chk("sdo_oe", 0, sdo_upper_oe_out);
    endtask
    task automatic t_sclk;
        rises = 0; run = 1;
        repeat (170) begin
            cyc(1);
            if (serial_clk_rise_out === 1'b1) rises++;
        end
        run = 0; chk("rises", 1, rises == 4);
        cyc(60);
        chk("sclk idle", 0, serial_clk_out);
    endtask
    task automatic t_irq;
        status_change_in = 1; cyc(1); status_change_in = 0; cyc(3);
        chk("irq", 0, status_change_irq_n_out);
        status_clear_in = 1; cyc(1); status_clear_in = 0; cyc(1);
        chk("irq clr", 1, status_change_irq_n_out);
    endtask
    task automatic t_dev_rst;
        status_change_in = 1; cyc(1); status_change_in = 0; device_reset_n_in = 0; cyc(5);
        chk("en rst", 0, clock_outputs_enable_out);
        chk("irq rst", 1, status_change_irq_n_out && device_reset_out);
        device_reset_n_in = 1; cyc(5);
        chk("en", 1, clock_outputs_enable_out);
        output_enable_n_in = 1; cyc(5);
        chk("en oe", 0, clock_outputs_enable_out);
        output_enable_n_in = 0;
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        cyc(2);
        chk("mode dflt", 1, i2c_mode_out);
        rst_in = 0;
        t_i2c(); t_spi(); t_sclk(); t_irq(); t_dev_rst();
        tally_and_finish();
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
endmodule
